/* design/omap_arbiter.sv */
// Output mode arbiter with AHB-Lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
//
// Overview of operation
// - Idle automatic: auto value, lamps dark, outputs low
// - Auto left by key or dynamic request
// - Auto only when all requests inactive
// - Manual request is toggle OR static-style external request
// - Static style: external request acts as level
// - Dynamic style: rising edge toggles manual state
// - Dynamic style: pin and serial requests both edge-triggered
// - Manual needs no safety, block, prior tracking
// - Pending manual request flashes lamp half rhythm
// - Tracking priority: tracking wins, lamp, status
// - Manual priority: manual wins, external lamp flashes
// - External-only manual request: lamp 90 percent on
// - Half rhythm has equal on and off
// - New mode starts from previous output value
// - Tracking value from analog input or serial
// - One block input freezes its direction only
// - Safety value, or end contacts for stepper
// - Manual absolute, or increment for steppers
// - Block over safety over manual/tracking over auto
// - Both block inputs freeze output entirely
module omap_arbiter import omap_pkg::*; #(
   parameter int W = 16,
   parameter int FLASH_CYC = FLASH_CYCLES,
   parameter logic [W-1:0] SAFE_HALF = 16'h8000,
   parameter logic [W-1:0] SAFE_RST = 16'h0000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic front_manual_key,
   input wire logic external_manual_request,
   input wire logic tracking_request,
   input wire logic safety_request,
   input wire logic [1:0] directional_block_inputs,
   input wire logic [W-1:0] analog_tracking_input,
   output logic [W-1:0] y_out,
   output logic manual_lamp,
   output logic external_lamp,
   output logic manual_active_output,
   output logic tracking_active_output,
   output logic drive_open,
   output logic drive_close
);
   localparam int FW = $clog2(FLASH_CYC);
   localparam logic [FW-1:0] CNT_LAST = FW'(FLASH_CYC - 1);
   localparam logic [FW-1:0] CNT_HALF = FW'(FLASH_CYC / RHYTHM_HALF_DIV);
   localparam logic [FW-1:0] CNT_TENTH = FW'(FLASH_CYC / RHYTHM_OFF_DIV);

   typedef struct packed {
      logic ready;
      logic wr;
      logic [7:0] wa;
      logic [31:0] rdata;
      logic prio;
      logic [2:0] style;
      logic [1:0] src;
      logic [1:0] ctype;
      logic ser_man;
      logic ser_prev;
      logic ext_prev;
      logic key_prev;
      logic toggle;
      logic [W-1:0] auto_v;
      logic [W-1:0] man;
      logic [W-1:0] safety;
      logic [W-1:0] ser;
      logic [W-1:0] y;
      omap_mode_t mode;
      logic lamp_man;
      logic lamp_ext;
      logic h;
      logic nw;
      logic open;
      logic close;
      logic [FW-1:0] cnt;
   } omap_state_t;

   omap_state_t s_r;
   omap_state_t s_nxt;
   logic [SYNC_W-1:0] sq;
   logic q_key;
   logic q_ext;
   logic q_trk;
   logic q_safe;
   logic [1:0] q_blk;

   omap_sync #(.W(SYNC_W)) omap_sync_i (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({front_manual_key, external_manual_request, tracking_request,
          safety_request, directional_block_inputs}),
      .q(sq)
   );
   assign {q_key, q_ext, q_trk, q_safe, q_blk} = sq;

   // Bit 0 blocks rises, bit 1 blocks falls
   function automatic logic [W-1:0] hold_dir(input logic [W-1:0] cand,
         input logic [W-1:0] cur, input logic [1:0] blk);
      logic [W-1:0] r;
      r = cand;
      if (blk[0] && cand > cur) begin
         r = cur;
      end
      if (blk[1] && cand < cur) begin
         r = cur;
      end
      return r;
   endfunction

   // Saturating signed step, keeps the value inside 0..max
   function automatic logic [W-1:0] step_add(input logic [W-1:0] cur,
         input logic [W-1:0] inc);
      logic [W:0] sum;
      sum = {1'b0, cur} + {inc[W-1], inc};
      // Negative step: bit W set means the result went below zero
      if (inc[W-1] && sum[W]) begin
         return '0;
      end else if (!inc[W-1] && sum[W]) begin
         return '1;
      end
      return sum[W-1:0];
   endfunction

   function automatic logic [31:0] rd_reg(input omap_state_t s,
         input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         ADDR_CTRL: begin
            d[CTRL_PRIO_BIT] = s.prio;
            d[CTRL_STYLE_LSB +: 3] = s.style;
            d[CTRL_SRC_LSB +: 2] = s.src;
            d[CTRL_TYPE_LSB +: 2] = s.ctype;
            d[CTRL_SERMAN_BIT] = s.ser_man;
         end
         ADDR_AUTO: d[W-1:0] = s.auto_v;
         ADDR_MAN: d[W-1:0] = s.man;
         ADDR_SAFE: d[W-1:0] = s.safety;
         ADDR_SER: d[W-1:0] = s.ser;
         ADDR_STAT: begin
            d[STAT_MODE_LSB +: 3] = s.mode;
            d[STAT_LAMP_MAN] = s.lamp_man;
            d[STAT_LAMP_EXT] = s.lamp_ext;
            d[STAT_H] = s.h;
            d[STAT_NW] = s.nw;
            d[STAT_TOGGLE] = s.toggle;
            d[STAT_OPEN] = s.open;
            d[STAT_CLOSE] = s.close;
         end
         ADDR_OUT: d[W-1:0] = s.y;
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   logic dyn;
   logic man_req;
   logic ext_only;
   logic blocked;
   logic half_on;
   logic ninety_on;
   logic pend;
   omap_mode_t base;
   logic [W-1:0] ext_val;
   logic [W-1:0] cand;

   always_comb begin
      s_nxt = s_r;
      s_nxt.ready = 1'b1;
      // Shared timebase for every flashing lamp
      s_nxt.cnt = (s_r.cnt == CNT_LAST) ? '0 : s_r.cnt + 1'b1;
      half_on = s_r.cnt >= CNT_HALF;
      ninety_on = s_r.cnt >= CNT_TENTH;
      dyn = (s_r.style == STYLE_DYN_A) || (s_r.style == STYLE_DYN_B);
      // Key and dynamic requests act on rising edges only
      s_nxt.key_prev = q_key;
      s_nxt.ext_prev = q_ext;
      s_nxt.ser_prev = s_r.ser_man;
      s_nxt.toggle = s_r.toggle ^ (q_key & ~s_r.key_prev)
         ^ (dyn & q_ext & ~s_r.ext_prev)
         ^ (dyn & s_r.ser_man & ~s_r.ser_prev);
      ext_only = ~dyn & q_ext & ~s_r.toggle;
      man_req = s_r.toggle | (~dyn & q_ext);
      blocked = |q_blk;
      // Priority chain ends in automatic as the last resort
      if (q_safe) begin
         base = MD_SAFE;
      end else if (s_r.prio == PRIO_TRACKING && q_trk) begin
         base = MD_TRACK;
      end else if (man_req) begin
         base = MD_MAN;
      end else if (q_trk) begin
         base = MD_TRACK;
      end else begin
         base = MD_AUTO;
      end
      ext_val = (s_r.src >= SRC_SERIAL_MIN) ? s_r.ser : analog_tracking_input;
      case (base)
         MD_MAN: cand = s_r.man;
         MD_TRACK: cand = (s_r.ctype == TYPE_STEP_INT) ? s_r.y : ext_val;
         MD_SAFE: cand = (s_r.ctype == TYPE_STEP_INT) ? s_r.y : s_r.safety;
         default: cand = s_r.auto_v;
      endcase
      s_nxt.y = hold_dir(cand, s_r.y, q_blk);
      s_nxt.mode = blocked ? MD_BLOCK : base;
      // Idle sources follow the output so a switch causes no step
      if (s_nxt.mode != MD_MAN) begin
         s_nxt.man = s_nxt.y;
      end
      if (s_nxt.mode != MD_AUTO) begin
         s_nxt.auto_v = s_nxt.y;
      end
      if (s_nxt.mode != MD_TRACK) begin
         s_nxt.ser = s_nxt.y;
      end
      pend = man_req && (s_nxt.mode != MD_MAN) && (s_nxt.mode != MD_AUTO);
      if (s_nxt.mode == MD_MAN) begin
         s_nxt.lamp_man = ext_only ? ninety_on : 1'b1;
      end else begin
         s_nxt.lamp_man = pend & half_on;
      end
      if (s_nxt.mode == MD_MAN) begin
         s_nxt.lamp_ext = (s_r.prio != PRIO_TRACKING) & q_trk & half_on;
      end else begin
         s_nxt.lamp_ext = s_nxt.mode != MD_AUTO;
      end
      s_nxt.h = man_req;
      s_nxt.nw = s_nxt.mode == MD_TRACK;
      // Stepper with internal feedback runs to an end stop instead
      s_nxt.open = s_nxt.mode == MD_SAFE && s_r.ctype == TYPE_STEP_INT
         && s_r.safety > SAFE_HALF;
      s_nxt.close = s_nxt.mode == MD_SAFE && s_r.ctype == TYPE_STEP_INT
         && s_r.safety <= SAFE_HALF;
      // Bus data phase; writes override the tracking above
      if (s_r.wr) begin
         case (s_r.wa)
            ADDR_CTRL: begin
               s_nxt.prio = hwdata[CTRL_PRIO_BIT];
               s_nxt.style = hwdata[CTRL_STYLE_LSB +: 3];
               s_nxt.src = hwdata[CTRL_SRC_LSB +: 2];
               s_nxt.ctype = hwdata[CTRL_TYPE_LSB +: 2];
               s_nxt.ser_man = hwdata[CTRL_SERMAN_BIT];
               s_nxt.toggle = s_nxt.toggle ^ hwdata[CTRL_KEY_BIT];
            end
            ADDR_AUTO: s_nxt.auto_v = hwdata[W-1:0];
            ADDR_MAN: begin
               if (s_r.ctype >= TYPE_STEP_MIN) begin
                  s_nxt.man = step_add(s_r.man, hwdata[W-1:0]);
               end else begin
                  s_nxt.man = hwdata[W-1:0];
               end
            end
            ADDR_SAFE: s_nxt.safety = hwdata[W-1:0];
            ADDR_SER: s_nxt.ser = hwdata[W-1:0];
            default: s_nxt.wa = s_r.wa;
         endcase
      end
      // Address phase; zero wait states so hready is never pulled low
      s_nxt.wr = hsel & hready & htrans[1] & hwrite;
      s_nxt.wa = haddr[7:0];
      s_nxt.rdata = (hsel & hready & htrans[1] & ~hwrite) ? rd_reg(s_r, haddr[7:0])
         : 32'h0000_0000;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
         s_r.ready <= 1'b1;
         s_r.prio <= CTRL_PRIO_RST;
         s_r.style <= CTRL_STYLE_RST;
         s_r.src <= CTRL_SRC_RST;
         s_r.ctype <= CTRL_TYPE_RST;
         s_r.safety <= SAFE_RST;
         s_r.mode <= MD_AUTO;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hreadyout = s_r.ready;
   assign hrdata = s_r.rdata;
   assign hresp = 1'b0;
   assign y_out = s_r.y;
   assign manual_lamp = s_r.lamp_man;
   assign external_lamp = s_r.lamp_ext;
   assign manual_active_output = s_r.h;
   assign tracking_active_output = s_r.nw;
   assign drive_open = s_r.open;
   assign drive_close = s_r.close;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_ext_rise;
      !q_ext ##1 q_ext;
   endsequence
   sequence s_free;
      !q_blk[0] && !q_blk[1] && !q_safe;
   endsequence

   a_auto_dark: assert property (s_r.mode == MD_AUTO |->
      !manual_lamp && !external_lamp && !manual_active_output && !tracking_active_output)
      else $error("automatic mode shows a lamp or status");
   a_both_blocked: assert property (q_blk == 2'b11 |=> $stable(y_out))
      else $error("output moved with both blocks active");
   a_rise_blocked: assert property (q_blk == 2'b01 |=> y_out <= $past(y_out))
      else $error("output rose against raise block");
   a_safety_value: assert property (q_blk == 2'b00 && q_safe
      && s_r.ctype != TYPE_STEP_INT |=> y_out == $past(s_r.safety) && !tracking_active_output)
      else $error("safety value not applied");
   a_track_wins: assert property (s_free ##0 q_trk && s_r.prio == PRIO_TRACKING
      |=> tracking_active_output && external_lamp)
      else $error("tracking did not take over");
   a_manual_wins: assert property (s_free ##0 q_trk && man_req
      && s_r.prio != PRIO_TRACKING |=> !tracking_active_output && s_r.mode == MD_MAN)
      else $error("manual priority not honoured");
   a_pend_flash: assert property (q_blk == 2'b00 && q_safe && man_req
      |=> manual_lamp == $past(half_on))
      else $error("pending manual lamp not flashing");
   a_dyn_toggle: assert property (s_ext_rise ##0 (dyn && !(q_key && !s_r.key_prev)
      && !(s_r.ser_man && !s_r.ser_prev) && !s_r.wr) |=> s_r.toggle != $past(s_r.toggle))
      else $error("edge did not toggle manual state");
   // A manual write lands in the source one cycle before it can reach the output
   a_bumpless: assert property (s_r.mode == MD_MAN && $past(s_r.mode) != MD_MAN
      && !$past(s_r.wr, 2) |-> y_out == $past(y_out))
      else $error("step on entering manual mode");
   a_static_level: assert property (s_free ##0 !q_trk && !dyn && q_ext
      |=> manual_active_output && s_r.mode == MD_MAN)
      else $error("static request did not give manual mode");
endmodule

/* include/omap_pkg.sv */
// Constants, register map and mode encoding of the output mode arbiter
package omap_pkg;
   // Register byte offsets (haddr[7:0])
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_AUTO = 8'h04;
   localparam logic [7:0] ADDR_MAN = 8'h08;
   localparam logic [7:0] ADDR_SAFE = 8'h0C;
   localparam logic [7:0] ADDR_SER = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   localparam logic [7:0] ADDR_OUT = 8'h18;
   // Control register fields
   localparam int CTRL_PRIO_BIT = 0;
   localparam int CTRL_STYLE_LSB = 1;
   localparam int CTRL_SRC_LSB = 4;
   localparam int CTRL_TYPE_LSB = 6;
   localparam int CTRL_KEY_BIT = 8;
   localparam int CTRL_SERMAN_BIT = 9;
   localparam logic CTRL_PRIO_RST = 1'b0;
   localparam logic [2:0] CTRL_STYLE_RST = 3'h0;
   localparam logic [1:0] CTRL_SRC_RST = 2'h0;
   localparam logic [1:0] CTRL_TYPE_RST = 2'h0;
   // Switch encodings
   localparam logic PRIO_TRACKING = 1'b0;
   localparam logic [2:0] STYLE_DYN_A = 3'h3;
   localparam logic [2:0] STYLE_DYN_B = 3'h4;
   localparam logic [1:0] SRC_SERIAL_MIN = 2'h2;
   localparam logic [1:0] TYPE_STEP_INT = 2'h2;
   localparam logic [1:0] TYPE_STEP_MIN = 2'h2;
   // Status register fields
   localparam int STAT_MODE_LSB = 0;
   localparam int STAT_LAMP_MAN = 3;
   localparam int STAT_LAMP_EXT = 4;
   localparam int STAT_H = 5;
   localparam int STAT_NW = 6;
   localparam int STAT_TOGGLE = 7;
   localparam int STAT_OPEN = 8;
   localparam int STAT_CLOSE = 9;
   // Flash timebase
   localparam int CLK_MHZ = 100;
   localparam int FLASH_PERIOD_MS = 1000;
   localparam int FLASH_CYCLES = FLASH_PERIOD_MS * 1000 * CLK_MHZ;
   localparam int RHYTHM_OFF_DIV = 10;
   localparam int RHYTHM_HALF_DIV = 2;
   localparam int SYNC_W = 6;
   typedef enum logic [2:0] {
      MD_AUTO = 3'b000,
      MD_MAN = 3'b001,
      MD_TRACK = 3'b011,
      MD_SAFE = 3'b010,
      MD_BLOCK = 3'b110
   } omap_mode_t;
endpackage

/* design/omap_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module omap_sync #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] f1_r;
   logic [W-1:0] f2_r;
   logic [W-1:0] f3_r;
   logic [W-1:0] q_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         f1_r <= '0;
         f2_r <= '0;
         f3_r <= '0;
         q_r <= '0;
      end else begin
         f1_r <= d;
         f2_r <= f1_r;
         f3_r <= f2_r;
         // Per bit: accept only once stages two and three agree
         q_r <= (q_r & (f2_r ^ f3_r)) | (f2_r & ~(f2_r ^ f3_r));
      end
   end

   assign q = q_r;
endmodule

/* tb/omap_plant.sv */
// Plant side model: control pins, front key and tracking source
`timescale 1ns/10ps
module omap_plant #(
   parameter int W = 16
) (
   input wire logic hclk,
   input wire logic [W-1:0] y_out,
   input wire logic tracking_active_output,
   output logic front_manual_key,
   output logic external_manual_request,
   output logic tracking_request,
   output logic safety_request,
   output logic [1:0] directional_block_inputs,
   output logic [W-1:0] analog_tracking_input
);
   logic [W-1:0] trk_val;
   initial begin
      {directional_block_inputs, safety_request, tracking_request} = 4'h0;
      {external_manual_request, front_manual_key} = 2'h0;
      trk_val = '0;
   end
   // Feeder follows the output so that taking over causes no step
   always @(posedge hclk) begin
      analog_tracking_input <= tracking_active_output ? trk_val : y_out;
   end
   // Called just after a rising edge
   task automatic set_pins(input logic [5:0] p, input logic [W-1:0] v);
      {directional_block_inputs, safety_request, tracking_request} <= p[5:2];
      {external_manual_request, front_manual_key} <= p[1:0];
      trk_val <= v;
   endtask
endmodule

/* tb/test_output_mode_arbiter.sv */
// Self-checking bench of the output mode arbiter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_output_mode_arbiter import omap_pkg::*; ;
   localparam int FC = 20;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, key, ext, trk, safe;
   logic mlamp, xlamp, man_o, trk_o, d_open, d_close;
   logic [1:0] htrans, blk;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] ana, y;
   int num_errors = 0;
   int n_compared = 0;

   omap_arbiter #(.FLASH_CYC(FC)) omap_arbiter_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .front_manual_key(key), .external_manual_request(ext),
      .tracking_request(trk), .safety_request(safe), .directional_block_inputs(blk),
      .analog_tracking_input(ana), .y_out(y), .manual_lamp(mlamp), .external_lamp(xlamp),
      .manual_active_output(man_o), .tracking_active_output(trk_o), .drive_open(d_open),
      .drive_close(d_close));
   omap_plant omap_plant_i (.hclk(hclk), .y_out(y), .tracking_active_output(trk_o),
      .front_manual_key(key), .external_manual_request(ext), .tracking_request(trk),
      .safety_request(safe), .directional_block_inputs(blk), .analog_tracking_input(ana));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic finish_test();
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Reads hreadyout as sampled at the edge, before that edge's updates land
   task automatic wait_rdy();
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 50) begin
            num_errors++;
            finish_test();
         end
         @(posedge hclk);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      `CHK("hresp", 1'b0, hresp)
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      bus(1'b1, a, {16'h0, v});
      repeat (3) @(posedge hclk);
   endtask

   // Fields: serial request, key, type, source, style, priority
   task automatic ctl(input logic [9:0] v);
      wr(ADDR_CTRL, {6'h0, v});
   endtask

   // Pin order: blocks[1:0], safety, tracking, external request, key
   task automatic pins(input logic [5:0] p, input logic [15:0] v);
      omap_plant_i.set_pins(p, v);
      repeat (8) @(posedge hclk);
   endtask

   task automatic flash(input logic x, input int e);
      int n;
      n = 0;
      repeat (FC) begin
         @(posedge hclk);
         n += int'(x ? xlamp : mlamp);
      end
      `CHK("lamp on count", e, n)
   endtask

   task automatic t_auto();
      `CHK("y reset", 16'h0, y)
      bus(1'b0, ADDR_CTRL, 32'h0);
      `CHK("ctrl reset", 32'h0, rd)
      bus(1'b0, 8'h40, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      wr(ADDR_AUTO, 16'h1234);
      `CHK("auto y", 16'h1234, y)
      `CHK("idle flags", 4'h0, {mlamp, xlamp, man_o, trk_o})
      bus(1'b0, ADDR_OUT, 32'h0);
      `CHK("out reg", 32'h1234, rd)
   endtask

   task automatic t_static();
      pins(6'h02, 16'h0);
      `CHK("switch y", 16'h1234, y)
      `CHK("H", 1'b1, man_o)
      flash(1'b0, FC - FC / 10);
      wr(ADDR_MAN, 16'h0500);
      `CHK("manual y", 16'h0500, y)
      pins(6'h00, 16'h0);
      `CHK("H released", 1'b0, man_o)
      `CHK("return y", 16'h0500, y)
   endtask

   task automatic t_dynamic();
      logic [2:0] st[2];
      st = '{STYLE_DYN_A, STYLE_DYN_B};
      foreach (st[i]) begin
         ctl({6'h0, st[i], 1'b0});
         pins(6'h02, 16'h0);
         `CHK("edge sets", 1'b1, man_o)
         pins(6'h00, 16'h0);
         `CHK("level ignored", 1'b1, man_o)
         pins(6'h02, 16'h0);
         pins(6'h00, 16'h0);
         `CHK("edge clears", 1'b0, man_o)
         ctl({6'h20, st[i], 1'b0});
         `CHK("serial edge", 1'b1, man_o)
         ctl({6'h20, st[i], 1'b0});
         `CHK("serial no edge", 1'b1, man_o)
         ctl({6'h10, st[i], 1'b0});
         `CHK("key write", 1'b0, man_o)
         pins(6'h01, 16'h0);
         pins(6'h00, 16'h0);
         `CHK("key pin", 1'b1, man_o)
         pins(6'h01, 16'h0);
         pins(6'h00, 16'h0);
      end
      ctl(10'h0);
   endtask

   task automatic t_track();
      pins(6'h06, 16'h2222);
      `CHK("track y", 16'h2222, y)
      `CHK("track flags", 3'h7, {xlamp, trk_o, man_o})
      flash(1'b0, FC / 2);
      ctl(10'h001);
      `CHK("manual wins", 2'h1, {trk_o, man_o})
      `CHK("no step", 16'h2222, y)
      flash(1'b1, FC / 2);
      ctl({6'h02, 3'h0, 1'b0});
      wr(ADDR_SER, 16'h3333);
      `CHK("serial track", 16'h3333, y)
      pins(6'h00, 16'h0);
      ctl(10'h0);
   endtask

   // Safety with a static manual request pending, then stepper steps both ways
   task automatic t_safety();
      wr(ADDR_SAFE, 16'h0ABC);
      pins(6'h0E, 16'h0);
      `CHK("safety y", 16'h0ABC, y)
      `CHK("safety flags", 2'h2, {xlamp, trk_o})
      flash(1'b0, FC / 2);
      ctl({4'h2, 6'h0});
      wr(ADDR_SAFE, 16'h9000);
      `CHK("drive open", 2'h2, {d_open, d_close})
      wr(ADDR_SAFE, 16'h1000);
      `CHK("drive close", 2'h1, {d_open, d_close})
      pins(6'h02, 16'h0);
      wr(ADDR_MAN, 16'h0010);
      `CHK("increment", 16'h0ACC, y)
      ctl({4'h3, 6'h0});
      wr(ADDR_MAN, 16'hFFF0);
      `CHK("decrement", 16'h0ABC, y)
      wr(ADDR_MAN, 16'h0010);
      `CHK("increment back", 16'h0ACC, y)
      pins(6'h00, 16'h0);
      ctl(10'h0);
   endtask

   task automatic t_block();
      pins(6'h1A, 16'h0);
      `CHK("block over safety", 16'h0ACC, y)
      `CHK("block lamp", 1'b1, xlamp)
      flash(1'b0, FC / 2);
      pins(6'h12, 16'h0);
      wr(ADDR_MAN, 16'h0100);
      `CHK("falling free", 16'h0100, y)
      wr(ADDR_MAN, 16'h0F00);
      `CHK("rising held", 16'h0100, y)
      pins(6'h32, 16'h0);
      wr(ADDR_MAN, 16'h0050);
      `CHK("both held", 16'h0100, y)
      pins(6'h00, 16'h0);
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_auto();
      t_static();
      t_dynamic();
      t_track();
      t_safety();
      t_block();
      finish_test();
   end
endmodule
